// ### shared/raster_pkg.sv
package raster_pkg;

  // Clock rate and the derived system clock timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int MCLK_HIGH_NS = 163;
  localparam int MCLK_PERIOD_NS = 326;
  localparam int MCLK_HIGH_CYC = (MCLK_HIGH_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 MCLK_HIGH_NS / CLK_PERIOD_NS;
  localparam int MCLK_PERIOD_CYC = (MCLK_PERIOD_NS / CLK_PERIOD_NS < 2) ? 2 :
                                   MCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MCLK_DIV_W = $clog2(MCLK_PERIOD_CYC);

  // Horizontal line layout in pels.
  localparam int H_W = 10;
  localparam logic [9:0] H_LAST = 10'h030B;
  localparam logic [9:0] H_HALF = 10'h0186;
  localparam logic [9:0] H_ACTIVE = 10'h0280;
  localparam logic [9:0] HSYNC_START = 10'h0290;
  localparam logic [9:0] HSYNC_END = 10'h02D0;
  localparam logic [2:0] CHAR_PHASE = 3'h7;

  // Vertical sync counter.
  localparam int VS_W = 4;
  localparam logic [3:0] VS_ON = 4'h8;
  localparam logic [3:0] VS_OFF = 4'hE;
  localparam logic [3:0] VS_HALT = 4'hF;
  localparam logic [3:0] VS_PRESET_F1 = 4'h0;
  localparam logic [3:0] VS_PRESET_F0 = 4'h1;

  // Vertical blanking length in lines per field.
  localparam int BLANK_W = 5;
  localparam logic [4:0] BLANK_F1 = 5'h17;
  localparam logic [4:0] BLANK_F0 = 5'h16;
  localparam logic [4:0] BLANK_LAST = 5'h01;

  // Synchronisation machine states and early enable codes {go, data, addr}.
  typedef enum logic [3:0] {
    SYNC_0 = 4'b0000, SYNC_1 = 4'b0001, SYNC_2 = 4'b0010, SYNC_3 = 4'b0011,
    SYNC_4 = 4'b0100, SYNC_5 = 4'b0101, SYNC_6 = 4'b0110,
    SYNC_8 = 4'b1000, SYNC_9 = 4'b1001, SYNC_10 = 4'b1010, SYNC_11 = 4'b1011,
    SYNC_12 = 4'b1100, SYNC_13 = 4'b1101, SYNC_14 = 4'b1110, SYNC_15 = 4'b1111
  } sync_state_e;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_GO = 3'h4;
  localparam logic [2:0] CODE_GO_ADDR = 3'h5;
  localparam logic [2:0] CODE_GO_DATA = 3'h6;
  localparam logic [2:0] CODE_ALL = 3'h7;
  localparam int CODE_GO_BIT = 2;
  localparam int CODE_DATA_BIT = 1;
  localparam int CODE_ADDR_BIT = 0;

  localparam int CURSOR_W = 8;
  localparam logic [7:0] CURSOR_CARRY = 8'hFF;

  // Register map.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_HCOUNT = 4'h8;
  localparam logic [3:0] REG_CURSOR = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_W = 2;
  localparam int CTRL_DISPLAY_ON_BIT = 0;
  localparam int CTRL_CURSOR_ON_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int ST_FIELD_BIT = 0;
  localparam int ST_VSYNC_BIT = 1;
  localparam int ST_VPE_BIT = 2;
  localparam int ST_LOCKED_BIT = 3;
  localparam int ST_STATE_LSB = 4;

endpackage

// ### shared/raster_timing_if.sv
`timescale 1ns/1ps
interface raster_timing_if;
  logic half_line_tick;
  logic line_start;
  logic last_line_done;
  logic field;
  logic vsync;
  logic vertical_picture_enable;
  modport source (
    output half_line_tick,
    output line_start,
    output last_line_done,
    input field,
    input vsync,
    input vertical_picture_enable
  );
  modport sink (
    input half_line_tick,
    input line_start,
    input last_line_done,
    output field,
    output vsync,
    output vertical_picture_enable
  );
endinterface

// ### hdl/vsync_gen.sv
`timescale 1ns/1ps
module vsync_gen (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Raster timing.
  raster_timing_if.sink tim
);

  logic field_reg;
  logic preset_pending_reg;
  logic [raster_pkg::VS_W-1:0] vs_cnt_reg;
  logic vsync_reg;
  logic vpe_reg;
  logic [raster_pkg::BLANK_W-1:0] blank_cnt_reg;

  assign tim.field = field_reg;
  assign tim.vsync = vsync_reg;
  assign tim.vertical_picture_enable = vpe_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preset_pending_reg <= 1'b0;
    end else if (tim.last_line_done) begin
      preset_pending_reg <= 1'b1;
    end else if (tim.half_line_tick) begin
      preset_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vs_cnt_reg <= raster_pkg::VS_HALT;
      field_reg <= 1'b1;
    end else if (tim.half_line_tick && preset_pending_reg) begin
      vs_cnt_reg <= field_reg ? raster_pkg::VS_PRESET_F1 : raster_pkg::VS_PRESET_F0;
      field_reg <= ~field_reg;
    end else if (tim.half_line_tick && vs_cnt_reg != raster_pkg::VS_HALT) begin
      vs_cnt_reg <= vs_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vsync_reg <= 1'b0;
    end else begin
      vsync_reg <= vs_cnt_reg >= raster_pkg::VS_ON && vs_cnt_reg <= raster_pkg::VS_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vpe_reg <= 1'b0;
      blank_cnt_reg <= raster_pkg::BLANK_F1;
    end else if (tim.last_line_done) begin
      vpe_reg <= 1'b0;
      blank_cnt_reg <= field_reg ? raster_pkg::BLANK_F1 : raster_pkg::BLANK_F0;
    end else if (tim.line_start && !vpe_reg) begin
      if (blank_cnt_reg <= raster_pkg::BLANK_LAST) begin
        vpe_reg <= 1'b1;
      end else begin
        blank_cnt_reg <= blank_cnt_reg - 5'h01;
      end
    end
  end

endmodule

// ### hdl/cpu_phase_sync.sv
`timescale 1ns/1ps
module cpu_phase_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // One-cycle tick per system clock period.
  input wire logic step,
  // Phase-seven pulses of both processors.
  input wire logic main_pulse,
  input wire logic disp_pulse,
  // State and enables.
  output raster_pkg::sync_state_e state,
  output logic go,
  output logic data_en,
  output logic addr_en,
  output logic mem_ctrl_en
);

  raster_pkg::sync_state_e state_reg;
  raster_pkg::sync_state_e state_next;
  logic [2:0] code_next;
  logic [2:0] code_reg;
  logic mem_ctrl_reg;

  assign state = state_reg;
  assign go = code_reg[raster_pkg::CODE_GO_BIT];
  assign data_en = code_reg[raster_pkg::CODE_DATA_BIT];
  assign addr_en = code_reg[raster_pkg::CODE_ADDR_BIT];
  assign mem_ctrl_en = mem_ctrl_reg;

  always_comb begin
    state_next = raster_pkg::SYNC_0;
    code_next = raster_pkg::CODE_GO;
    unique case ({main_pulse, disp_pulse})
      2'b01: begin
        state_next = raster_pkg::SYNC_6;
        code_next = raster_pkg::CODE_NONE;
        if (state_reg inside {raster_pkg::SYNC_2, raster_pkg::SYNC_3, raster_pkg::SYNC_4,
                              raster_pkg::SYNC_5, raster_pkg::SYNC_6}) begin
          state_next = raster_pkg::SYNC_0;
          code_next = raster_pkg::CODE_GO;
        end else if (state_reg == raster_pkg::SYNC_11) begin
          state_next = raster_pkg::SYNC_12;
          code_next = raster_pkg::CODE_GO;
        end
      end
      2'b11: begin
        state_next = raster_pkg::SYNC_2;
        code_next = raster_pkg::CODE_NONE;
        if (state_reg inside {raster_pkg::SYNC_2, raster_pkg::SYNC_3, raster_pkg::SYNC_4,
                              raster_pkg::SYNC_5, raster_pkg::SYNC_6}) begin
          state_next = raster_pkg::SYNC_0;
          code_next = raster_pkg::CODE_GO;
        end
      end
      2'b10: begin
        if (state_reg == raster_pkg::SYNC_6) begin
          state_next = raster_pkg::SYNC_2;
          code_next = raster_pkg::CODE_NONE;
        end else if (state_reg == raster_pkg::SYNC_15) begin
          state_next = raster_pkg::SYNC_8;
          code_next = raster_pkg::CODE_ALL;
        end
      end
      2'b00: begin
        unique case (state_reg)
          raster_pkg::SYNC_1, raster_pkg::SYNC_12: begin
            state_next = raster_pkg::SYNC_13;
            code_next = raster_pkg::CODE_GO_ADDR;
          end
          raster_pkg::SYNC_2: begin
            state_next = raster_pkg::SYNC_3;
            code_next = raster_pkg::CODE_NONE;
          end
          raster_pkg::SYNC_3: begin
            state_next = raster_pkg::SYNC_4;
            code_next = raster_pkg::CODE_NONE;
          end
          raster_pkg::SYNC_4: begin
            state_next = raster_pkg::SYNC_5;
            code_next = raster_pkg::CODE_NONE;
          end
          raster_pkg::SYNC_5: begin
            state_next = raster_pkg::SYNC_1;
          end
          raster_pkg::SYNC_6: begin
            state_next = raster_pkg::SYNC_6;
            code_next = raster_pkg::CODE_NONE;
          end
          raster_pkg::SYNC_8: begin
            state_next = raster_pkg::SYNC_9;
            code_next = raster_pkg::CODE_GO_DATA;
          end
          raster_pkg::SYNC_9: begin
            state_next = raster_pkg::SYNC_10;
            code_next = raster_pkg::CODE_GO_DATA;
          end
          raster_pkg::SYNC_10: begin
            state_next = raster_pkg::SYNC_11;
            code_next = raster_pkg::CODE_GO_DATA;
          end
          raster_pkg::SYNC_13: begin
            state_next = raster_pkg::SYNC_14;
            code_next = raster_pkg::CODE_GO_ADDR;
          end
          raster_pkg::SYNC_14: begin
            state_next = raster_pkg::SYNC_15;
            code_next = raster_pkg::CODE_GO_ADDR;
          end
          default: begin
            state_next = raster_pkg::SYNC_0;
            code_next = raster_pkg::CODE_GO;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= raster_pkg::SYNC_0;
      code_reg <= raster_pkg::CODE_GO;
      mem_ctrl_reg <= 1'b1;
    end else if (step) begin
      state_reg <= state_next;
      code_reg <= code_next;
      mem_ctrl_reg <= state_next != raster_pkg::SYNC_11;
    end
  end

endmodule

// ### hdl/video_raster_control.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module video_raster_control (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Pel clock from the oscillator.
  input wire logic pel_clock,
  // Processor phase pulses and memory cycle qualifiers.
  input wire logic display_cpu_phase_pulse,
  input wire logic main_cpu_phase_pulse,
  input wire logic dma_cycle,
  input wire logic scan_pair_load_time,
  // Character rows and cursor load.
  input wire logic last_line_done,
  input wire logic cursor_load,
  input wire logic [7:0] cursor_value,
  input wire logic char_strobe,
  input wire logic [6:0] char_data,
  // Clocks to the boards.
  output logic system_master_clock,
  output logic board_clock,
  output logic board_clock_n,
  // Raster timing.
  output logic hsync,
  output logic hblank,
  output logic char_load,
  output logic vsync,
  output logic vertical_picture_enable,
  output logic field,
  // Processor synchronisation.
  output logic display_hold_n,
  output logic addr_bus_en,
  output logic data_bus_en,
  output logic mem_ctrl_en,
  // Line buffer write port.
  output logic [7:0] line_buf_wdata,
  output logic line_buf_we,
  // AXI4-Lite slave.
  input wire logic [raster_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [raster_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  raster_timing_if tim ();

  logic pel_meta_reg;
  logic pel_sync_reg;
  logic pel_prev_reg;
  logic pel_tick;
  logic main_meta_reg;
  logic main_sync_reg;
  logic disp_meta_reg;
  logic disp_sync_reg;
  logic [raster_pkg::H_W-1:0] h_cnt_reg;
  logic [raster_pkg::MCLK_DIV_W-1:0] mclk_cnt_reg;
  logic mclk_step;
  logic half_tick_reg;
  logic line_start_reg;
  logic last_line_reg;
  logic hsync_reg;
  logic hblank_reg;
  logic char_load_reg;
  logic mclk_reg;
  logic bclk_reg;
  logic bclk_n_reg;
  logic vsync_reg;
  logic vpe_reg;
  logic field_reg;
  raster_pkg::sync_state_e sync_state;
  logic sync_go;
  logic sync_data_en;
  logic sync_addr_en;
  logic sync_mem_en;
  logic hold_n_reg;
  logic addr_en_reg;
  logic data_en_reg;
  logic mem_en_reg;
  logic [raster_pkg::CURSOR_W-1:0] cursor_cnt_reg;
  logic [7:0] lb_data_reg;
  logic lb_we_reg;
  logic [raster_pkg::CTRL_W-1:0] ctrl_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_mux;
  logic rd_hit;

  // Pel clock and processor pulses are retimed by two flip-flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pel_meta_reg <= 1'b0;
      pel_sync_reg <= 1'b0;
      pel_prev_reg <= 1'b0;
      main_meta_reg <= 1'b0;
      main_sync_reg <= 1'b0;
      disp_meta_reg <= 1'b0;
      disp_sync_reg <= 1'b0;
    end else begin
      pel_meta_reg <= pel_clock;
      pel_sync_reg <= pel_meta_reg;
      pel_prev_reg <= pel_sync_reg;
      main_meta_reg <= main_cpu_phase_pulse;
      main_sync_reg <= main_meta_reg;
      disp_meta_reg <= display_cpu_phase_pulse;
      disp_sync_reg <= disp_meta_reg;
    end
  end

  assign pel_tick = pel_sync_reg & ~pel_prev_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      h_cnt_reg <= '0;
    end else if (pel_tick) begin
      if (h_cnt_reg == raster_pkg::H_LAST) begin
        h_cnt_reg <= '0;
      end else begin
        h_cnt_reg <= h_cnt_reg + 10'h001;
      end
    end
  end

  // Horizontal decode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hsync_reg <= 1'b0;
      hblank_reg <= 1'b0;
      char_load_reg <= 1'b0;
      half_tick_reg <= 1'b0;
      line_start_reg <= 1'b0;
      last_line_reg <= 1'b0;
    end else begin
      hsync_reg <= h_cnt_reg >= raster_pkg::HSYNC_START && h_cnt_reg < raster_pkg::HSYNC_END;
      hblank_reg <= h_cnt_reg >= raster_pkg::H_ACTIVE;
      char_load_reg <= pel_tick && h_cnt_reg[2:0] == raster_pkg::CHAR_PHASE;
      half_tick_reg <= pel_tick && (h_cnt_reg == '0 || h_cnt_reg == raster_pkg::H_HALF);
      line_start_reg <= pel_tick && h_cnt_reg == '0;
      last_line_reg <= last_line_done;
    end
  end

  assign tim.half_line_tick = half_tick_reg;
  assign tim.line_start = line_start_reg;
  assign tim.last_line_done = last_line_reg;

  vsync_gen u_vsync (
    .clk(clk),
    .sys_rst(sys_rst),
    .tim(tim.sink)
  );

  // System and board clocks.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mclk_cnt_reg <= '0;
    end else if (mclk_cnt_reg == raster_pkg::MCLK_DIV_W'(raster_pkg::MCLK_PERIOD_CYC - 1)) begin
      mclk_cnt_reg <= '0;
    end else begin
      mclk_cnt_reg <= mclk_cnt_reg + raster_pkg::MCLK_DIV_W'(1);
    end
  end

  assign mclk_step = mclk_cnt_reg == '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mclk_reg <= 1'b0;
      bclk_reg <= 1'b0;
      bclk_n_reg <= 1'b1;
    end else begin
      mclk_reg <= mclk_cnt_reg < raster_pkg::MCLK_DIV_W'(raster_pkg::MCLK_HIGH_CYC);
      bclk_reg <= mclk_cnt_reg < raster_pkg::MCLK_DIV_W'(raster_pkg::MCLK_HIGH_CYC);
      bclk_n_reg <= mclk_cnt_reg >= raster_pkg::MCLK_DIV_W'(raster_pkg::MCLK_HIGH_CYC);
    end
  end

  cpu_phase_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(mclk_step),
    .main_pulse(main_sync_reg),
    .disp_pulse(disp_sync_reg),
    .state(sync_state),
    .go(sync_go),
    .data_en(sync_data_en),
    .addr_en(sync_addr_en),
    .mem_ctrl_en(sync_mem_en)
  );

  // Registered copies of block state for the outputs, except picture enable, which is masked by display-on.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_n_reg <= 1'b1;
      addr_en_reg <= 1'b0;
      data_en_reg <= 1'b0;
      mem_en_reg <= 1'b1;
      vsync_reg <= 1'b0;
      vpe_reg <= 1'b0;
      field_reg <= 1'b1;
    end else begin
      hold_n_reg <= sync_go;
      addr_en_reg <= sync_addr_en;
      data_en_reg <= sync_data_en;
      mem_en_reg <= sync_mem_en;
      vsync_reg <= tim.vsync;
      vpe_reg <= tim.vertical_picture_enable & ctrl_reg[raster_pkg::CTRL_DISPLAY_ON_BIT];
      field_reg <= tim.field;
    end
  end

  // Cursor counter.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cursor_cnt_reg <= '0;
    end else if (cursor_load) begin
      cursor_cnt_reg <= cursor_value;
    end else if (dma_cycle && !scan_pair_load_time) begin
      cursor_cnt_reg <= cursor_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lb_data_reg <= '0;
      lb_we_reg <= 1'b0;
    end else begin
      lb_we_reg <= char_strobe;
      if (char_strobe) begin
        lb_data_reg <= {cursor_cnt_reg == raster_pkg::CURSOR_CARRY && dma_cycle &&
                        !scan_pair_load_time && ctrl_reg[raster_pkg::CTRL_CURSOR_ON_BIT],
                        char_data};
      end
    end
  end

  // Register bus: both write channels are taken in one cycle.
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
  assign rd_take = s_axi_arvalid && !arready_reg && !rvalid_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= raster_pkg::RESP_OKAY;
      ctrl_reg <= raster_pkg::CTRL_RESET;
    end else begin
      awready_reg <= wr_take;
      wready_reg <= wr_take;
      if (wr_take) begin
        if (s_axi_awaddr == raster_pkg::REG_CTRL) begin
          bresp_reg <= raster_pkg::RESP_OKAY;
          if (s_axi_wstrb[0]) begin
            ctrl_reg <= s_axi_wdata[raster_pkg::CTRL_W-1:0];
          end
        end else if (s_axi_awaddr == raster_pkg::REG_STATUS ||
                     s_axi_awaddr == raster_pkg::REG_HCOUNT ||
                     s_axi_awaddr == raster_pkg::REG_CURSOR) begin
          bresp_reg <= raster_pkg::RESP_OKAY;
        end else begin
          bresp_reg <= raster_pkg::RESP_SLVERR;
        end
      end
      if (awready_reg) begin
        bvalid_reg <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      raster_pkg::REG_CTRL: rd_mux[raster_pkg::CTRL_W-1:0] = ctrl_reg;
      raster_pkg::REG_STATUS: begin
        rd_mux[raster_pkg::ST_FIELD_BIT] = field_reg;
        rd_mux[raster_pkg::ST_VSYNC_BIT] = vsync_reg;
        rd_mux[raster_pkg::ST_VPE_BIT] = tim.vertical_picture_enable;
        rd_mux[raster_pkg::ST_LOCKED_BIT] = sync_state[3];
        rd_mux[raster_pkg::ST_STATE_LSB +: 4] = sync_state;
      end
      raster_pkg::REG_HCOUNT: rd_mux[raster_pkg::H_W-1:0] = h_cnt_reg;
      raster_pkg::REG_CURSOR: rd_mux[raster_pkg::CURSOR_W-1:0] = cursor_cnt_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= raster_pkg::RESP_OKAY;
    end else begin
      arready_reg <= rd_take;
      if (rd_take) begin
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? raster_pkg::RESP_OKAY : raster_pkg::RESP_SLVERR;
      end
      if (arready_reg) begin
        rvalid_reg <= 1'b1;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign system_master_clock = mclk_reg;
  assign board_clock = bclk_reg;
  assign board_clock_n = bclk_n_reg;
  assign hsync = hsync_reg;
  assign hblank = hblank_reg;
  assign char_load = char_load_reg;
  assign vsync = vsync_reg;
  assign vertical_picture_enable = vpe_reg;
  assign field = field_reg;
  assign display_hold_n = hold_n_reg;
  assign addr_bus_en = addr_en_reg;
  assign data_bus_en = data_en_reg;
  assign mem_ctrl_en = mem_en_reg;
  assign line_buf_wdata = lb_data_reg;
  assign line_buf_we = lb_we_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

// ### test/raster_monitor.sv
`timescale 1ns/1ps
module raster_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports.
  input wire logic system_master_clock,
  input wire logic board_clock,
  input wire logic board_clock_n,
  input wire logic hsync,
  input wire logic hblank,
  input wire logic char_load,
  input wire logic vsync,
  input wire logic vertical_picture_enable,
  input wire logic field,
  input wire logic display_hold_n,
  input wire logic last_line_done,
  input wire logic char_strobe,
  input wire logic line_buf_we
);
  default clocking @(posedge clk); endclocking
  clk_pair_a: assert property (disable iff (sys_rst) board_clock_n != board_clock)
    else $error("clock pair");
  clk_width_a: assert property (disable iff (sys_rst) $rose(system_master_clock)
    |=> system_master_clock [*7] ##1 !system_master_clock) else $error("clock width");
  sync_blank_a: assert property (disable iff (sys_rst) hsync |-> hblank)
    else $error("hsync");
  char_pulse_a: assert property (disable iff (sys_rst) char_load |=> !char_load)
    else $error("char load");
  vpe_drop_a: assert property (disable iff (sys_rst) last_line_done
    |-> ##3 !vertical_picture_enable [*3]) else $error("picture enable");
  vsync_blank_a: assert property (disable iff (sys_rst) vsync |-> !vertical_picture_enable)
    else $error("vsync");
  reset_state_a: assert property (sys_rst |=> field && !vsync && display_hold_n)
    else $error("reset");
  buf_write_a: assert property (disable iff (sys_rst) char_strobe |=> line_buf_we)
    else $error("buffer write");
endmodule

// ### test/cpu_pair_model.sv
`timescale 1ns/1ps
module cpu_pair_model (
  // Clock and hold.
  input wire logic system_master_clock,
  input wire logic display_hold_n,
  // Pins to the block.
  output logic pel_clock,
  output logic main_pulse,
  output logic disp_pulse
);
  logic [2:0] main_phase = 3'h0;
  logic [2:0] disp_phase = 3'h5;
  initial begin
    pel_clock = 1'b0;
    forever #40.74 pel_clock = ~pel_clock;
  end
  always @(posedge system_master_clock) begin
    main_phase <= main_phase + 3'h1;
    if (display_hold_n) disp_phase <= disp_phase + 3'h1;
  end
  assign main_pulse = main_phase == 3'h7;
  assign disp_pulse = disp_phase == 3'h7;
endmodule

// ### test/video_raster_control_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h want %0h", $time, a, e); end end
module video_raster_control_bench;
  logic clk, sys_rst, pel_clock, dma_cycle, scan_pair_load_time, last_line_done, cursor_load;
  logic char_strobe, main_cpu_phase_pulse, display_cpu_phase_pulse, system_master_clock;
  logic board_clock, board_clock_n, hsync, hblank, char_load, vsync, vertical_picture_enable;
  logic field, display_hold_n, addr_bus_en, data_bus_en, mem_ctrl_en, line_buf_we;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] cursor_value, line_buf_wdata;
  logic [6:0] char_data;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int failures, n_checks, cycles, pels, h_mark, v0, ph0, ph1, lines, ln0;
  video_raster_control video_raster_control_i (.*);
  cpu_pair_model cpu_pair_model_i (.system_master_clock, .display_hold_n, .pel_clock,
    .main_pulse(main_cpu_phase_pulse), .disp_pulse(display_cpu_phase_pulse));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge pel_clock) pels++;
  always @(posedge hsync) begin
    h_mark = pels;
    lines++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 105000) begin
      failures++;
      finish_test();
    end
  end
  task finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task axw(input logic [3:0] a);
    @(posedge clk);
    s_axi_awaddr <= a;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task frame;
    @(posedge hsync);
    @(posedge clk);
    last_line_done <= 1'b1;
    ln0 = lines;
    @(posedge clk);
    last_line_done <= 1'b0;
    @(posedge vsync);
    ph0 = pels - h_mark;
    v0 = pels;
    @(negedge vsync);
    `CHK(pels - v0, 2730)
  endtask
  initial begin
    sys_rst = 1'b1;
    {dma_cycle, scan_pair_load_time, last_line_done, cursor_load, char_strobe} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cursor_value, char_data, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'hFFFF_FFFF;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    axr(raster_pkg::REG_CTRL);
    `CHK(rd[1:0], raster_pkg::CTRL_RESET)
    axr(raster_pkg::REG_STATUS);
    `CHK(rd[7:0], 8'h01)
    axr(4'h6);
    `CHK(rs, raster_pkg::RESP_SLVERR)
    axw(4'h2);
    `CHK(rs, raster_pkg::RESP_SLVERR)
    $display("registers done");
    cursor_value <= 8'hFD;
    cursor_load <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {cursor_load, scan_pair_load_time} <= {1'b0, i == 0};
      {dma_cycle, char_strobe, char_data} <= {2'h3, 7'(7'h41 + i)};
      @(posedge clk);
      {dma_cycle, char_strobe} <= 2'h0;
      @(posedge clk);
      `CHK(line_buf_wdata, {i == 3, 7'(7'h41 + i)})
    end
    $display("cursor done");
    s_axi_wdata <= 32'h0000_0001;
    axw(raster_pkg::REG_CTRL);
    `CHK(rs, raster_pkg::RESP_OKAY)
    axr(raster_pkg::REG_CTRL);
    `CHK(rd[1:0], 2'h1)
    frame();
    ph1 = ph0;
    `CHK(field, 1'b0)
    repeat (6) @(posedge hsync);
    `CHK(vsync, 1'b0)
    v0 = pels;
    @(posedge hsync);
    `CHK(pels - v0, 780)
    axr(raster_pkg::REG_HCOUNT);
    `CHK(rd[9:0] < 10'h30C, 1'b1)
    @(posedge vertical_picture_enable);
    `CHK(lines - ln0, 22)
    frame();
    `CHK(field, 1'b1)
    `CHK((ph0 - ph1 + 780) % 780, 390)
    $display("raster done");
    axr(raster_pkg::REG_STATUS);
    `CHK(rd[raster_pkg::ST_LOCKED_BIT], 1'b1)
    @(posedge main_cpu_phase_pulse);
    `CHK(cpu_pair_model_i.disp_phase, 3'h3)
    $display("sync done");
    finish_test();
  end
endmodule
bind video_raster_control raster_monitor raster_monitor_i (.*);
